// file: vian_defs.svh
`ifndef VIAN_DEFS_SVH
`define VIAN_DEFS_SVH

// ****************************************************************
// Register map, one aligned 32-bit word each.
// ****************************************************************
`define VIAN_OFF_CTRL 8'h00
`define VIAN_OFF_ENABLE 8'h04
`define VIAN_OFF_PEND 8'h08
`define VIAN_OFF_STATUS 8'h0C
`define VIAN_CTRL_GIE_BIT 0
`define VIAN_CTRL_RESET 32'h0000_0000
`define VIAN_ENABLE_RESET 16'h0000
`define VIAN_STATUS_STATE_LSB 8

// ****************************************************************
// Source layout: bit i of the source vector selects vector E0 + 2*i.
// ****************************************************************
`define VIAN_NSRC 16
`define VIAN_TRAP_BIT 15
`define VIAN_EN_MASK 16'h3E3E

// ****************************************************************
// Core constants.
// ****************************************************************
`define VIAN_TRAP_OPCODE 8'h00
`define VIAN_ACK_PC 15'h00FF
`define VIAN_POP_PC 15'h7FFF
`define VIAN_STACK_LIMIT 8'h6F
`define VIAN_VEC_BASE 8'hE0
`define VIAN_BLOCK_LAST 8'hFF
`define VIAN_ACK_CYCLES 7

// ****************************************************************
// AXI responses.
// ****************************************************************
`define VIAN_RESP_OKAY 2'h0
`define VIAN_RESP_SLVERR 2'h2

`endif

// file: vian_pkg.sv
package vian_pkg;

  typedef enum logic [3:0] {
    VIAN_S_IDLE = 4'h1,
    VIAN_S_ACK = 4'h2,
    VIAN_S_FHI = 4'h4,
    VIAN_S_FLO = 4'h8
  } vian_state_t;

  // Merges a bus write into an old word under the byte strobes.
  function automatic logic [31:0] vian_wmerge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// file: vian_rank.sv
`timescale 1ns/10ps
`default_nettype none

`include "vian_defs.svh"

module vian_rank
  import vian_pkg::*;
#(
  parameter int NSRC = 16
) (
  input wire logic [NSRC-1:0] active,
  output logic [7:0] offset
);

  // ****************************************************************
  // The offset arithmetic only covers sixteen even slots.
  // ****************************************************************
  if (NSRC != `VIAN_NSRC) begin : g_bad_nsrc
    $error("vian_rank supports exactly sixteen sources");
  end

  // Highest set index wins; an empty vector falls to the default slot.
  function automatic logic [7:0] rank_off(input logic [NSRC-1:0] act);
    logic [7:0] res;
    res = `VIAN_VEC_BASE;
    for (int i = 1; i < NSRC; i++) begin
      if (act[i]) begin
        res = 8'(`VIAN_VEC_BASE + 8'(2 * i));
      end
    end
    return res;
  endfunction

  always_comb begin
    offset = rank_off(active);
  end

endmodule

`default_nettype wire

// file: vian_arbiter.sv
`timescale 1ns/10ps
`default_nettype none

`include "vian_defs.svh"

module vian_arbiter
  import vian_pkg::*;
#(
  parameter int ACK_CYCLES = `VIAN_ACK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic icyc,
  input wire logic insn_start,
  input wire logic [14:0] next_addr,
  input wire logic ir_load,
  input wire logic [7:0] ir_opcode,
  input wire logic [14:0] ir_addr,
  input wire logic vis_exec,
  input wire logic [14:0] vis_addr,
  input wire logic clear_trap_pending_instruction_exec,
  input wire logic return_from_irq_exec,
  input wire logic [14:0] stack_pop_addr,
  input wire logic [7:0] stack_sp,
  input wire logic [15:0] src_pend,
  output logic pm_rd_req,
  output logic [14:0] pm_rd_addr,
  input wire logic [7:0] pm_rd_data,
  input wire logic pm_rd_valid,
  output logic pc_load,
  output logic [14:0] pc_load_val,
  output logic push_req,
  output logic [14:0] push_addr,
  output logic irq_ack,
  output logic gie_out,
  output logic busy
);

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  if (ACK_CYCLES < 1 || ACK_CYCLES > 15) begin : g_bad_ack
    $error("ACK_CYCLES must lie between 1 and 15");
  end

  localparam logic [3:0] ACK_LAST = 4'(ACK_CYCLES - 1);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  vian_state_t state_ff;
  logic [3:0] ack_cnt_ff;
  logic trap_pend_ff;
  logic trap_req_ff;
  logic [14:0] trap_addr_ff;
  logic gie_ff;
  logic [15:0] en_ff;
  logic [14:0] vec_addr_ff;
  logic [7:0] vec_hi_ff;
  logic [7:0] last_off_ff;
  logic [7:0] rank_off;
  logic [15:0] mask_active;
  logic [15:0] arb_active;
  logic [6:0] tbl_block;
  logic trap_event;
  logic take_mask;
  logic idle;
  logic start_trap;
  logic start_return_from_irq;
  logic start_vis;
  logic start_mask;
  logic [7:0] aw_addr_ff;
  logic aw_got_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_got_ff;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_do;
  logic wr_ctrl;
  logic wr_en;
  logic wr_known;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // ****************************************************************
  // Source qualification and ranking.
  // ****************************************************************
  assign trap_event = ir_load && (ir_opcode == `VIAN_TRAP_OPCODE);
  assign mask_active = src_pend & en_ff & `VIAN_EN_MASK;
  // The trap flag fences off every maskable source; clearing it reopens.
  assign take_mask = insn_start && gie_ff && !trap_pend_ff &&
                     (|mask_active);
  assign arb_active = {trap_pend_ff, mask_active[14:0]};
  assign tbl_block = (vis_addr[7:0] == `VIAN_BLOCK_LAST) ?
                     7'(vis_addr[14:8] + 7'h01) : vis_addr[14:8];

  assign idle = (state_ff == VIAN_S_IDLE);
  assign start_trap = idle && trap_req_ff;
  assign start_return_from_irq = idle && !trap_req_ff && return_from_irq_exec;
  assign start_vis = idle && !trap_req_ff && !return_from_irq_exec && vis_exec;
  assign start_mask = idle && !trap_req_ff && !return_from_irq_exec && !vis_exec &&
                      take_mask;

  vian_rank #(
    .NSRC(`VIAN_NSRC)
  ) u_rank (
    .active(arb_active),
    .offset(rank_off)
  );

  // ****************************************************************
  // Trap pending flag, internal only.
  // ****************************************************************
  // A trap arriving in the same cycle as the clear keeps the flag set.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trap_pend_ff <= 1'b0;
    end else if (trap_event) begin
      trap_pend_ff <= 1'b1;
    end else if (clear_trap_pending_instruction_exec) begin
      trap_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      trap_req_ff <= 1'b0;
      trap_addr_ff <= 15'h0000;
    end else if (trap_event) begin
      trap_req_ff <= 1'b1;
      trap_addr_ff <= ir_addr;
    end else if (start_trap) begin
      trap_req_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Global interrupt enable.
  // ****************************************************************
  // A trap entry is deliberately absent here, so the enable survives it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      gie_ff <= 1'b0;
    end else if (start_mask) begin
      gie_ff <= 1'b0;
    end else if (start_return_from_irq) begin
      gie_ff <= 1'b1;
    end else if (wr_ctrl && w_strb_ff[0]) begin
      gie_ff <= w_data_ff[`VIAN_CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      en_ff <= `VIAN_ENABLE_RESET;
    end else if (wr_en) begin
      en_ff <= 16'(vian_wmerge({16'h0000, en_ff}, w_data_ff,
                               w_strb_ff)) & `VIAN_EN_MASK;
    end
  end

  // ****************************************************************
  // Sequencer: acknowledge, return and vector dispatch.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= VIAN_S_IDLE;
      ack_cnt_ff <= 4'h0;
      pc_load <= 1'b0;
      pc_load_val <= 15'h0000;
      push_req <= 1'b0;
      push_addr <= 15'h0000;
      irq_ack <= 1'b0;
      pm_rd_req <= 1'b0;
      pm_rd_addr <= 15'h0000;
      vec_addr_ff <= 15'h0000;
      vec_hi_ff <= 8'h00;
      last_off_ff <= 8'h00;
    end else begin
      pc_load <= 1'b0;
      push_req <= 1'b0;
      irq_ack <= 1'b0;
      unique case (state_ff)
        VIAN_S_IDLE: begin
          ack_cnt_ff <= 4'h0;
          if (start_trap) begin
            push_req <= 1'b1;
            push_addr <= trap_addr_ff;
            irq_ack <= 1'b1;
            state_ff <= VIAN_S_ACK;
          end else if (start_return_from_irq) begin
            pc_load <= 1'b1;
            if (stack_sp > `VIAN_STACK_LIMIT) begin
              pc_load_val <= `VIAN_POP_PC;
            end else begin
              pc_load_val <= stack_pop_addr;
            end
          end else if (start_vis) begin
            last_off_ff <= rank_off;
            vec_addr_ff <= {tbl_block, rank_off};
            pc_load <= 1'b1;
            pc_load_val <= {tbl_block, rank_off};
            pm_rd_req <= 1'b1;
            pm_rd_addr <= {tbl_block, rank_off};
            state_ff <= VIAN_S_FHI;
          end else if (start_mask) begin
            push_req <= 1'b1;
            push_addr <= next_addr;
            irq_ack <= 1'b1;
            state_ff <= VIAN_S_ACK;
          end
        end
        VIAN_S_ACK: begin
          if (icyc) begin
            if (ack_cnt_ff == ACK_LAST) begin
              pc_load <= 1'b1;
              pc_load_val <= `VIAN_ACK_PC;
              state_ff <= VIAN_S_IDLE;
            end else begin
              ack_cnt_ff <= 4'(ack_cnt_ff + 4'h1);
            end
          end
        end
        VIAN_S_FHI: begin
          if (pm_rd_valid) begin
            vec_hi_ff <= pm_rd_data;
            pm_rd_addr <= {vec_addr_ff[14:1], 1'b1};
            state_ff <= VIAN_S_FLO;
          end
        end
        VIAN_S_FLO: begin
          if (pm_rd_valid) begin
            pm_rd_req <= 1'b0;
            pc_load <= 1'b1;
            pc_load_val <= {vec_hi_ff[6:0], pm_rd_data};
            state_ff <= VIAN_S_IDLE;
          end
        end
      endcase
    end
  end

  assign gie_out = gie_ff;
  assign busy = !idle;

  // ****************************************************************
  // AXI4-Lite write path.
  // ****************************************************************
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_ctrl = wr_do && (aw_addr_ff == `VIAN_OFF_CTRL);
  assign wr_en = wr_do && (aw_addr_ff == `VIAN_OFF_ENABLE);
  assign wr_known = (aw_addr_ff == `VIAN_OFF_CTRL) ||
                    (aw_addr_ff == `VIAN_OFF_ENABLE) ||
                    (aw_addr_ff == `VIAN_OFF_PEND) ||
                    (aw_addr_ff == `VIAN_OFF_STATUS);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else begin
      s_axi_awready <= !aw_got_ff && !aw_hs && !s_axi_bvalid;
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_got_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      s_axi_wready <= !w_got_ff && !w_hs && !s_axi_bvalid;
      if (w_hs) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VIAN_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `VIAN_RESP_OKAY : `VIAN_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read path.
  // ****************************************************************
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // The trap flag is left out of every word on purpose.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `VIAN_RESP_OKAY;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `VIAN_OFF_CTRL: nxt_rdata[`VIAN_CTRL_GIE_BIT] = gie_ff;
      `VIAN_OFF_ENABLE: nxt_rdata[15:0] = en_ff;
      `VIAN_OFF_PEND: nxt_rdata[15:0] = src_pend & `VIAN_EN_MASK;
      `VIAN_OFF_STATUS: begin
        nxt_rdata[7:0] = last_off_ff;
        nxt_rdata[`VIAN_STATUS_STATE_LSB +: 4] = state_ff;
      end
      default: nxt_rresp = `VIAN_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `VIAN_RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_hs && !s_axi_rvalid;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: vian_arbiter_checker.sv
`timescale 1ns/10ps
`default_nettype none
module vian_arbiter_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ir_load,
  input wire logic [7:0] ir_opcode,
  input wire logic [14:0] ir_addr,
  input wire logic vis_exec,
  input wire logic [14:0] vis_addr,
  input wire logic clear_trap_pending_instruction_exec,
  input wire logic return_from_irq_exec,
  input wire logic insn_start,
  input wire logic [14:0] stack_pop_addr,
  input wire logic [7:0] stack_sp,
  input wire logic pm_rd_req,
  input wire logic [14:0] pm_rd_addr,
  input wire logic [7:0] pm_rd_data,
  input wire logic pm_rd_valid,
  input wire logic pc_load,
  input wire logic [14:0] pc_load_val,
  input wire logic push_req,
  input wire logic [14:0] push_addr,
  input wire logic irq_ack,
  input wire logic gie_out,
  input wire logic busy
);
  logic trap_ev;
  logic trap_ff;
  logic [14:0] trap_addr_ff;
  logic [6:0] blk;
  assign trap_ev = ir_load && ir_opcode == 8'h00;
  assign blk = vis_addr[14:8] + 7'(vis_addr[7:0] == 8'hFF);
  // Mirrors the hidden trap flag; a new trap beats a clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trap_ff <= 1'b0;
    end else if (trap_ev) begin
      trap_ff <= 1'b1;
    end else if (clear_trap_pending_instruction_exec) begin
      trap_ff <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (trap_ev) begin
      trap_addr_ff <= ir_addr;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_vis_go;
    vis_exec && !busy && !trap_ev;
  endsequence
  sequence s_fetch_done;
    pm_rd_req && pm_rd_valid && pm_rd_addr[0];
  endsequence
  a_vis_even: assert property (
    s_vis_go |=> pc_load && pc_load_val[7:5] == 3'h7 && !pc_load_val[0])
    else $error("dispatch offset outside even E0..FE");
  a_vis_block: assert property (
    s_vis_go |=> pc_load_val[14:8] == $past(blk))
    else $error("dispatch high byte wrong");
  a_trap_wins: assert property (
    s_vis_go ##0 trap_ff |=> pc_load_val[7:0] == 8'hFE)
    else $error("pending trap did not give FE");
  a_fetch_even: assert property (
    s_vis_go |=> pm_rd_req && pm_rd_addr == pc_load_val)
    else $error("vector fetch not at table entry");
  a_vec_load: assert property (
    s_fetch_done |=> pc_load && !pm_rd_req &&
    pc_load_val[7:0] == $past(pm_rd_data))
    else $error("vector low byte not loaded");
  a_return_from_irq_ret: assert property (
    return_from_irq_exec && !busy && !trap_ev |=> pc_load && pc_load_val ==
    ($past(stack_sp) > 8'h6F ? 15'h7FFF : $past(stack_pop_addr)))
    else $error("return target wrong");
  a_return_from_irq_gie: assert property (
    return_from_irq_exec && !busy && !trap_ev |-> ##[1:2] gie_out)
    else $error("return did not set global enable");
  a_trap_push: assert property (
    trap_ev && !busy |-> ##[1:2] irq_ack && push_req &&
    push_addr == trap_addr_ff)
    else $error("trap not taken with its own address");
  a_trap_gie: assert property (
    irq_ack && trap_ff |=> $stable(gie_out))
    else $error("trap changed global enable");
  a_mask_block: assert property (
    insn_start && !busy && (trap_ff || !gie_out) && !trap_ev &&
    !$past(trap_ev) |=> !irq_ack)
    else $error("maskable taken while blocked");
  a_ack_gie: assert property (
    irq_ack && !trap_ff |-> ##[0:1] !gie_out)
    else $error("acknowledge kept global enable");
endmodule
bind vian_arbiter vian_arbiter_checker chk_u (.mclk, .rst, .ir_load,
  .ir_opcode, .ir_addr, .vis_exec, .vis_addr, .clear_trap_pending_instruction_exec, .return_from_irq_exec,
  .insn_start, .stack_pop_addr, .stack_sp, .pm_rd_req, .pm_rd_addr,
  .pm_rd_data, .pm_rd_valid, .pc_load, .pc_load_val, .push_req,
  .push_addr, .irq_ack, .gie_out, .busy);
`default_nettype wire

// file: vian_pmem_model.sv
`timescale 1ns/10ps
`default_nettype none
module vian_pmem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic pm_rd_req,
  input wire logic [14:0] pm_rd_addr,
  output logic [7:0] pm_rd_data,
  output logic pm_rd_valid
);
  logic [2:0] wait_ff;
  // Upper half is absent; even bytes hold the high byte, odd the low.
  function automatic logic [7:0] mem_byte(input logic [14:0] a);
    if (a[14]) begin
      return 8'h00;
    end
    return a[0] ? a[7:0] ^ 8'h5A : {1'b1, a[14:8]};
  endfunction
  // Data toggles whenever it is not valid and reset is low, so stale bytes never pass.
  always_ff @(posedge mclk) begin
    if (rst || !pm_rd_req || pm_rd_valid) begin
      wait_ff <= 3'h0;
      pm_rd_valid <= 1'b0;
      pm_rd_data <= rst ? 8'h00 : ~pm_rd_data;
    end else if (wait_ff == (slow ? 3'h4 : 3'h0)) begin
      pm_rd_valid <= 1'b1;
      pm_rd_data <= mem_byte(pm_rd_addr);
    end else begin
      wait_ff <= wait_ff + 3'h1;
      pm_rd_data <= ~pm_rd_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "vian_defs.svh"
module testbench;
  localparam int ACK = 7;
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, icyc, insn_start, ir_load, vis_exec;
  logic clear_trap_pending_instruction_exec, return_from_irq_exec, slow, pm_rd_req, pm_rd_valid, pc_load;
  logic push_req, irq_ack, gie_out, busy;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ir_opcode, stack_sp, pm_rd_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, icnt;
  logic [14:0] next_addr, ir_addr, vis_addr, stack_pop_addr, pm_rd_addr;
  logic [14:0] pc_load_val, push_addr;
  logic [15:0] src_pend;
  int bad_count, num_checks;
  vian_arbiter #(.ACK_CYCLES(ACK)) dut_u (.*);
  vian_pmem_model mem_u (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Instruction-cycle pulse, one in four clocks, restarted by reset.
  always @(posedge mclk) begin
    if (rst) begin
      icnt <= 2'h0;
      icyc <= 1'b0;
    end else begin
      icnt <= icnt + 2'h1;
      icyc <= icnt == 2'h3;
    end
  end
  // ***********
  // Shared tasks
  // ***********
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_for(input int which);
    int k;
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit && k < 300) begin
      @(posedge mclk);
      k++;
      hit = which == 0 ? pc_load === 1'b1 :
            which == 1 ? irq_ack === 1'b1 : busy === 1'b0;
    end
    chk("handshake", 32'h1, 32'(hit));
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready ||
               s_axi_wvalid && !s_axi_wready);
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write response", 32'(er), 32'(s_axi_bresp));
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("read data", exp, s_axi_rdata);
    chk("read response", 32'(er), 32'(s_axi_rresp));
    @(posedge mclk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Runs one dispatch and checks the offset jump and the fetched vector.
  task automatic do_vis(input logic [14:0] a, input logic [7:0] off,
                        input logic [6:0] blk);
    vis_addr <= a;
    vis_exec <= 1'b1;
    @(posedge mclk);
    vis_exec <= 1'b0;
    wait_for(0);
    chk("offset jump", 32'({blk, off}), 32'(pc_load_val));
    wait_for(0);
    chk("vector", 32'({blk, {off[7:1], 1'b1} ^ 8'h5A}), 32'(pc_load_val));
    wait_for(2);
  endtask
  // ***********
  // Scenarios
  // ***********
  task automatic t_regs();
    rd_chk(`VIAN_OFF_CTRL, 32'h0, `VIAN_RESP_OKAY);
    rd_chk(`VIAN_OFF_ENABLE, 32'h0, `VIAN_RESP_OKAY);
    wr_chk(`VIAN_OFF_ENABLE, 32'hFFFF_FFFF, `VIAN_RESP_OKAY);
    rd_chk(`VIAN_OFF_ENABLE, 32'h3E3E, `VIAN_RESP_OKAY);
    wr_chk(8'h10, 32'h1, `VIAN_RESP_SLVERR);
    rd_chk(8'h10, 32'h0, `VIAN_RESP_SLVERR);
    src_pend <= 16'h2222;
    rd_chk(`VIAN_OFF_PEND, 32'h2222, `VIAN_RESP_OKAY);
  endtask
  task automatic t_rank();
    src_pend <= 16'hC1C1;
    do_vis(15'h0105, 8'hE0, 7'h01);
    slow <= 1'b1;
    for (int i = 1; i < 14; i++) begin
      if (i < 6 || i > 8) begin
        src_pend <= 16'h0002 | (16'h0001 << i);
        do_vis(15'h0105, 8'hE0 + 8'(2 * i), 7'h01);
      end
    end
    slow <= 1'b0;
    src_pend <= 16'h2000;
    do_vis(15'h02FF, 8'hFA, 7'h03);
    do_vis(15'h02FE, 8'hFA, 7'h02);
    wr_chk(`VIAN_OFF_ENABLE, 32'h0, `VIAN_RESP_OKAY);
    do_vis(15'h0105, 8'hE0, 7'h01);
    wr_chk(`VIAN_OFF_ENABLE, 32'hFFFF, `VIAN_RESP_OKAY);
  endtask
  task automatic t_trap();
    int n;
    wr_chk(`VIAN_OFF_CTRL, 32'h1, `VIAN_RESP_OKAY);
    ir_opcode <= 8'h00;
    ir_addr <= 15'h4123;
    ir_load <= 1'b1;
    @(posedge mclk);
    ir_load <= 1'b0;
    wait_for(1);
    chk("trap push", 32'h4123, 32'(push_addr));
    n = 0;
    while (pc_load !== 1'b1 && n < 300) begin
      n += 32'(icyc);
      @(posedge mclk);
    end
    chk("ack cycles", 32'(ACK), 32'(n));
    chk("ack target", 32'h00FF, 32'(pc_load_val));
    rd_chk(`VIAN_OFF_CTRL, 32'h1, `VIAN_RESP_OKAY);
    do_vis(15'h00FF, 8'hFE, 7'h01);
    next_addr <= 15'h0234;
    insn_start <= 1'b1;
    @(posedge mclk);
    insn_start <= 1'b0;
    repeat (3) begin
      @(posedge mclk);
      chk("held off", 32'h0, 32'(irq_ack));
    end
    clear_trap_pending_instruction_exec <= 1'b1;
    @(posedge mclk);
    clear_trap_pending_instruction_exec <= 1'b0;
    insn_start <= 1'b1;
    @(posedge mclk);
    insn_start <= 1'b0;
    wait_for(1);
    chk("mask push", 32'h0234, 32'(push_addr));
    wait_for(0);
    chk("mask target", 32'h00FF, 32'(pc_load_val));
    rd_chk(`VIAN_OFF_CTRL, 32'h0, `VIAN_RESP_OKAY);
    do_vis(15'h00FF, 8'hFA, 7'h01);
    stack_pop_addr <= 15'h1357;
    stack_sp <= 8'h6F;
    return_from_irq_exec <= 1'b1;
    @(posedge mclk);
    return_from_irq_exec <= 1'b0;
    wait_for(0);
    chk("return target", 32'h1357, 32'(pc_load_val));
    rd_chk(`VIAN_OFF_CTRL, 32'h1, `VIAN_RESP_OKAY);
    stack_sp <= 8'h70;
    return_from_irq_exec <= 1'b1;
    @(posedge mclk);
    return_from_irq_exec <= 1'b0;
    wait_for(0);
    chk("overpop target", 32'h7FFF, 32'(pc_load_val));
  endtask
  task automatic t_reset();
    src_pend <= 16'h0;
    ir_addr <= 15'h0400;
    ir_load <= 1'b1;
    @(posedge mclk);
    ir_load <= 1'b0;
    wait_for(1);
    do_reset();
    do_vis(15'h0105, 8'hE0, 7'h01);
    rd_chk(`VIAN_OFF_CTRL, 32'h0, `VIAN_RESP_OKAY);
  endtask
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, insn_start, ir_load, vis_exec, clear_trap_pending_instruction_exec} = '0;
    {return_from_irq_exec, slow, s_axi_awaddr, s_axi_araddr, ir_opcode} = '0;
    {stack_sp, s_axi_wdata, next_addr, ir_addr, vis_addr} = '0;
    {stack_pop_addr, src_pend} = '0;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    num_checks = 0;
    do_reset();
    t_regs();
    t_rank();
    t_trap();
    t_reset();
    give_verdict();
  end
  // The scenarios need a few hundred cycles; this allows about 50000.
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
